// ==== design/trace_capture.sv ====
// partitioned trace capture: apb register slave, qualification, snapshot sequencing
// assumes sample, resource and break inputs are synchronous to pclk
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module trace_capture
	import trace_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WORD_W-1:0] sample_word,
	input wire logic sample_valid,
	input wire logic res_a,
	input wire logic res_b,
	input wire logic res_c,
	input wire logic enable_evt,
	input wire logic disable_evt,
	input wire logic brk_evt,
	input wire logic manual_brk,
	output logic emu_halt,
	output logic recording
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// memory index from partition and in-partition offset
	function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] p, input logic [ADDR_W-1:0] o,
		input logic [3:0] lg);
		addr_of = ADDR_W'({2'b00, p} << (4'd10 - lg)) | o;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [WORD_W-1:0] mem [DEPTH];
	logic [DEPTH-1:0] tmark;
	logic [CTRL_W-1:0] ctrl, next_ctrl;
	logic [3:0] part_log, next_part_log;
	logic [15:0] delay, next_delay;
	logic [15:0] snap_n, next_snap_n;
	logic [ADDR_W-1:0] rd_idx, next_rd_idx;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	cap_state_t st, next_st;
	logic [7:0] part, next_part, brk_part, next_brk_part;
	logic [ADDR_W-1:0] off, next_off, trig_addr, next_trig_addr;
	logic [15:0] dcnt, next_dcnt, tcount, next_tcount, cyc_num, next_cyc_num;
	logic run_d, bp_seen, next_bp_seen, final_act, next_final_act;
	logic en_flag, next_en_flag, dis_flag, next_dis_flag;
	logic next_emu_halt, next_recording;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;

	// ----------------------------------------
	// decoded configuration
	// ----------------------------------------
	logic [3:0] plog;
	logic [7:0] pmask;
	logic [ADDR_W-1:0] omask;
	logic [15:0] dly_val;
	trig_mode_t tmode;
	stop_mode_t smode;
	qual_src_t qsrc;
	logic cwin, trig_raw, win, qres, qual;

	// partition split and delay preset
	always_comb begin
		plog = (part_log > 4'(MAX_PLOG)) ? 4'(MAX_PLOG) : part_log;
		pmask = 8'((9'h001 << plog) - 9'h001);
		omask = ADDR_W'((11'h001 << (4'd10 - plog)) - 11'h001);
		tmode = trig_mode_t'(ctrl[CTRL_TMODE +: 2]);
		smode = stop_mode_t'(ctrl[CTRL_STOP +: 2]);
		qsrc = qual_src_t'(ctrl[CTRL_QSRC +: 2]);
		cwin = ctrl[CTRL_CWIN];
		case (tmode)
			TM_PRE: dly_val = 16'h0000;
			TM_CENTER: dly_val = 16'({6'h00, omask} + 16'h0001) >> 1;
			TM_POST: dly_val = {6'h00, omask};
			TM_CUSTOM: dly_val = delay;
			default: dly_val = 16'h0000;
		endcase
	end

	// trigger, window and qualifier
	always_comb begin
		// c is consumed by the window when in window mode
		trig_raw = |(ctrl[CTRL_TSEL +: 3] & {res_c & ~cwin, res_b, res_a});
		win = ~cwin | ((~ctrl[CTRL_EN] | en_flag) & (~ctrl[CTRL_DIS] | ~dis_flag));
		case (qsrc)
			Q_ALL: qres = 1'b1;
			Q_A: qres = res_a;
			Q_B: qres = res_b;
			Q_C: qres = res_c & ~cwin;
			default: qres = 1'b1;
		endcase
		qual = qres & win;
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// one wait state: answer registered in the second access cycle
	always_comb begin
		next_ctrl = ctrl;
		next_part_log = part_log;
		next_delay = delay;
		next_snap_n = snap_n;
		next_rd_idx = rd_idx;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_pready = psel & penable & ~pready;
		if (psel & penable & ~pready) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				OFF_CTRL: begin
					next_prdata = {19'h00000, ctrl};
					if (pwrite) next_ctrl = pwdata[CTRL_W-1:0];
				end
				OFF_PART: begin
					next_prdata = {28'h0000000, part_log};
					if (pwrite) next_part_log = pwdata[3:0];
				end
				OFF_DELAY: begin
					next_prdata = {16'h0000, delay};
					if (pwrite) next_delay = pwdata[15:0];
				end
				OFF_COUNT: begin
					next_prdata = {16'h0000, snap_n};
					if (pwrite) next_snap_n = pwdata[15:0];
				end
				OFF_RDIDX: begin
					next_prdata = {22'h000000, rd_idx};
					if (pwrite) next_rd_idx = pwdata[ADDR_W-1:0];
				end
				OFF_STATUS: next_prdata = {9'h000, emu_halt, st, bp_seen, final_act, part, off};
				OFF_RDLO: next_prdata = mem[rd_idx][31:0];
				OFF_RDHI: next_prdata = mem[rd_idx][63:32];
				OFF_RDTAG: next_prdata = {31'h00000000, tmark[rd_idx]};
				OFF_CYCNUM: next_prdata = {16'h0000, cyc_num};
				OFF_MARKS: next_prdata = {8'h00, brk_part, 6'h00, trig_addr};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RST;
			part_log <= PART_RST;
			delay <= DELAY_RST;
			snap_n <= COUNT_RST;
			rd_idx <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			part_log <= next_part_log;
			delay <= next_delay;
			snap_n <= next_snap_n;
			rd_idx <= next_rd_idx;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------
	// capture sequencer
	// ----------------------------------------
	logic act, trig, wr, new_snap, is_final, stop_now, end_part;
	logic [7:0] wpart;
	logic [ADDR_W-1:0] woff, waddr;
	logic [15:0] tc_inc, goal;

	always_comb begin
		next_st = st;
		next_part = part;
		next_off = off;
		next_dcnt = dcnt;
		next_tcount = tcount;
		next_cyc_num = cyc_num;
		next_bp_seen = bp_seen;
		next_final_act = final_act;
		next_en_flag = en_flag;
		next_dis_flag = dis_flag;
		next_brk_part = brk_part;
		next_trig_addr = trig_addr;
		next_emu_halt = emu_halt;
		end_part = 1'b0;
		act = sample_valid & ((st == ST_REC) | (st == ST_DELAY));
		trig = act & trig_raw;
		wr = act & (qual | trig);
		// a trigger opens a snapshot unless the final one is already running
		new_snap = trig & ((st == ST_REC) | ~final_act);
		wpart = part;
		woff = off;
		if ((st == ST_DELAY) & new_snap) begin
			wpart = 8'(part + 8'h01) & pmask;
			woff = '0;
		end
		waddr = addr_of(wpart, woff, plog);
		tc_inc = 16'(tcount + 16'h0001);
		goal = (snap_n == 16'h0000) ? 16'h0001 : snap_n;
		is_final = ((smode == SM_COUNT) | ((smode == SM_BRK_COUNT) & bp_seen)) & (tc_inc >= goal);
		stop_now = act & (manual_brk | ((smode == SM_BREAK) & brk_evt));
		wr_en = 1'b0;
		wr_addr = waddr;
		if (ctrl[CTRL_RUN] & ~run_d) begin
			// fresh run starts in the first partition
			next_st = ST_REC;
			next_part = 8'h00;
			next_off = '0;
			next_tcount = 16'h0000;
			next_cyc_num = 16'h0000;
			next_bp_seen = 1'b0;
			next_final_act = 1'b0;
			next_en_flag = 1'b0;
			next_dis_flag = 1'b0;
			next_brk_part = 8'h00;
			next_emu_halt = 1'b0;
		end else if (~ctrl[CTRL_RUN]) begin
			next_st = ST_IDLE;
		end else if (act) begin
			if (enable_evt) next_en_flag = 1'b1;
			if (disable_evt) next_dis_flag = 1'b1;
			if (brk_evt & ~bp_seen) begin
				next_bp_seen = 1'b1;
				next_tcount = 16'h0000;
				next_brk_part = part;
			end
			if (stop_now) begin
				next_st = ST_STOP;
				next_emu_halt = 1'b1;
				if (~bp_seen & ~brk_evt) next_brk_part = part;
			end else if (wr) begin
				wr_en = 1'b1;
				next_part = wpart;
				next_off = 10'(woff + 10'h001) & omask;
				if (new_snap) begin
					next_tcount = (brk_evt & ~bp_seen) ? 16'h0000 : tc_inc;
					next_final_act = is_final & ~(brk_evt & ~bp_seen);
					next_cyc_num = 16'h0000;
					next_trig_addr = waddr;
					next_dcnt = dly_val;
					if (dly_val == 16'h0000) end_part = 1'b1;
					else next_st = ST_DELAY;
				end else begin
					next_cyc_num = 16'(cyc_num + 16'h0001);
					if (st == ST_DELAY) begin
						next_dcnt = 16'(dcnt - 16'h0001);
						if (dcnt == 16'h0001) end_part = 1'b1;
					end
				end
				if (end_part) begin
					if (next_final_act) begin
						next_st = ST_STOP;
						next_emu_halt = 1'b1;
						if (~next_bp_seen) next_brk_part = wpart;
					end else begin
						next_part = 8'(wpart + 8'h01) & pmask;
						next_off = '0;
						next_st = ST_REC;
					end
				end
			end
		end else if (manual_brk & ((st == ST_REC) | (st == ST_DELAY))) begin
			next_st = ST_STOP;
			next_emu_halt = 1'b1;
			if (~bp_seen) next_brk_part = part;
		end
		next_recording = (next_st == ST_REC) | (next_st == ST_DELAY);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_IDLE;
			part <= 8'h00;
			off <= '0;
			dcnt <= 16'h0000;
			tcount <= 16'h0000;
			cyc_num <= 16'h0000;
			run_d <= 1'b0;
			bp_seen <= 1'b0;
			final_act <= 1'b0;
			en_flag <= 1'b0;
			dis_flag <= 1'b0;
			brk_part <= 8'h00;
			trig_addr <= '0;
			emu_halt <= 1'b0;
			recording <= 1'b0;
		end else begin
			st <= next_st;
			part <= next_part;
			off <= next_off;
			dcnt <= next_dcnt;
			tcount <= next_tcount;
			cyc_num <= next_cyc_num;
			run_d <= ctrl[CTRL_RUN];
			bp_seen <= next_bp_seen;
			final_act <= next_final_act;
			en_flag <= next_en_flag;
			dis_flag <= next_dis_flag;
			brk_part <= next_brk_part;
			trig_addr <= next_trig_addr;
			emu_halt <= next_emu_halt;
			recording <= next_recording;
		end
	end

	// ----------------------------------------
	// trace memory
	// ----------------------------------------
	// sample word and trigger mark stored together
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= sample_word;
			tmark[wr_addr] <= trig;
		end
	end

endmodule

`default_nettype wire

// ==== design/trace_pkg.sv ====
// constants, register map and types of the partitioned trace capture block
// assumes one apb clock domain; sample and trigger inputs come from logic on that clock
// Operation
// - memory holds 1024 words of 64 bits, one written per qualified trace event
// - memory splits into 1 to 256 equal partitions, depth 1024 over count
// - each trigger up to the final one yields one snapshot; the end of the final snapshot stops the target
// - snapshot counter halts after n triggers following the breakpoint
// - pre-trigger mode ends the snapshot on the trigger cycle itself
// - center-trigger mode records half the snapshot depth after the trigger
// - post-trigger mode records a full depth starting with the trigger cycle
// - cycle delay after the trigger is freely programmable
// - delay may exceed depth; buffer wraps and keeps the last depth cycles
// - without any trigger recording keeps overwriting until a manual break, or in break mode a breakpoint
// - cycles are numbered from the trigger, trigger is zero
// - resource a, b or c may qualify which cycles get written
// - enable qualifies cycles after its event, disable stops qualifying after its event
// - enable/disable window exists only with resource c in window mode
// - trigger and final trigger cycles are written unless a manual break or, in break mode, a breakpoint stops the run in that cycle
// - with qualification the delay counts qualified cycles only
// - recording starts in partition zero and advances after each trigger plus delay
// - after the last partition the pointer wraps to the first one
// - stop on trigger count, on breakpoint or manual break, or breakpoint then count
// - snapshots are numbered from the breakpoint partition, newest zero
// - a new trigger during a running delay ends the partition at once
// - extra triggers after the final trigger are only marked, numbering kept
package trace_pkg;

	localparam int WORD_W = 64;
	localparam int DEPTH = 1024;
	localparam int ADDR_W = 10;
	localparam int MAX_PLOG = 8;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PART = 8'h04;
	localparam logic [7:0] OFF_DELAY = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_RDIDX = 8'h14;
	localparam logic [7:0] OFF_RDLO = 8'h18;
	localparam logic [7:0] OFF_RDHI = 8'h1c;
	localparam logic [7:0] OFF_RDTAG = 8'h20;
	localparam logic [7:0] OFF_CYCNUM = 8'h24;
	localparam logic [7:0] OFF_MARKS = 8'h28;

	// control field positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_TMODE = 1;
	localparam int CTRL_QSRC = 3;
	localparam int CTRL_EN = 5;
	localparam int CTRL_DIS = 6;
	localparam int CTRL_STOP = 7;
	localparam int CTRL_TSEL = 9;
	localparam int CTRL_CWIN = 12;
	localparam int CTRL_W = 13;

	// status and marks field positions
	localparam int STAT_PART = 10;
	localparam int STAT_FINAL = 18;
	localparam int STAT_BP = 19;
	localparam int STAT_STATE = 20;
	localparam int STAT_HALT = 22;
	localparam int MARK_BRK = 16;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
	localparam logic [3:0] PART_RST = 4'h0;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0001;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REC = 2'b01,
		ST_DELAY = 2'b10,
		ST_STOP = 2'b11
	} cap_state_t;

	typedef enum logic [1:0] {
		TM_PRE = 2'b00,
		TM_CENTER = 2'b01,
		TM_POST = 2'b10,
		TM_CUSTOM = 2'b11
	} trig_mode_t;

	typedef enum logic [1:0] {
		SM_COUNT = 2'b00,
		SM_BREAK = 2'b01,
		SM_BRK_COUNT = 2'b10
	} stop_mode_t;

	typedef enum logic [1:0] {
		Q_ALL = 2'b00,
		Q_A = 2'b01,
		Q_B = 2'b10,
		Q_C = 2'b11
	} qual_src_t;

endpackage

// ==== tb/sample_source.sv ====
// emulator side model: numbered sample words and trigger resource lines
// assumes the bench steers it with level knobs set just after pclk edges
`timescale 1ns/100ps
`default_nettype none
module sample_source (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic qa,
	input wire logic trg,
	input wire logic bp,
	output logic [63:0] word,
	output logic valid,
	output logic ra,
	output logic rb,
	output logic brk
);
	logic [31:0] cnt;
	// one word per bus cycle, inverted junk between cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h0;
			word <= 64'h0;
			valid <= 1'b0;
			{ra, rb, brk} <= 3'b000;
		end else begin
			valid <= go;
			word <= go ? {~cnt, cnt} : ~word;
			cnt <= cnt + (go ? 32'h1 : 32'h0);
			ra <= qa & cnt[0];
			rb <= trg;
			brk <= bp & go;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_partitioned_trace_capture.sv ====
// self-checking bench of the trace capture block with its emulator model
// assumes the apb slave answers one cycle after the access is taken
`timescale 1ns/100ps
`default_nettype none
module tb_partitioned_trace_capture import trace_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv, tw;
	logic pready, pslverr, err, sample_valid, res_a, res_b, brk_evt, emu_halt, recording;
	logic [63:0] sample_word;
	logic res_c = 0, enable_evt = 0, disable_evt = 0, manual_brk = 0;
	logic go = 0, qa = 0, trg = 0, bp = 0, qon = 0;
	int n_errors = 0, checks_done = 0, ncnt = 0;
	always #5 pclk = ~pclk;
	trace_capture dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_word(sample_word), .sample_valid(sample_valid), .res_a(res_a), .res_b(res_b), .res_c(res_c),
		.enable_evt(enable_evt), .disable_evt(disable_evt), .brk_evt(brk_evt), .manual_brk(manual_brk),
		.emu_halt(emu_halt), .recording(recording));
	sample_source src_u (.clk(pclk), .rst_n(presetn), .go(go), .qa(qa), .trg(trg), .bp(bp),
		.word(sample_word), .valid(sample_valid), .ra(res_a), .rb(res_b), .brk(brk_evt));
	// trigger word and written cycles after it
	always @(posedge pclk) begin
		if (sample_valid && recording) begin
			if (res_b) begin
				ncnt <= 0;
				tw <= sample_word[31:0];
			end else if (!qon || res_a) begin
				ncnt <= ncnt + 1;
			end
		end
	end
	task give_verdict;
		if (n_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task hang;
		n_errors++;
		$display("CHECK FAILED at %0t: timeout", $time);
		give_verdict;
	endtask
	// one apb transfer, waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang;
		rdv = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask
	// one-cycle knob pulse after an idle gap: {trigger, manual, breakpoint}
	task pulse(input int idle, input logic [2:0] s);
		repeat (idle) @(posedge pclk);
		{trg, manual_brk, bp} <= s;
		@(posedge pclk);
		{trg, manual_brk, bp} <= 3'b000;
	endtask
	task wait_stop;
		int n;
		n = 0;
		while (recording !== 1'b0 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) hang;
		repeat (2) @(posedge pclk);
	endtask
	task start(input logic [31:0] c, input logic [31:0] p, input logic [31:0] d, input logic [31:0] n);
		apb(1'b1, OFF_PART, p);
		apb(1'b1, OFF_DELAY, d);
		apb(1'b1, OFF_COUNT, n);
		apb(1'b1, OFF_CTRL, c);
		apb(1'b1, OFF_CTRL, c | 32'h1);
	endtask
	// one snapshot: trigger on b, measure the delay, read the trigger entry
	task run_mode(input logic [31:0] c, input int p, input logic [31:0] d, input int exp);
		logic [31:0] m;
		qon = c[4:3] != 2'b00;
		qa <= qon;
		start(c, p, d, 32'h1);
		pulse(12, 3'b100);
		wait_stop;
		chk(ncnt, exp);
		chk(32'(emu_halt), 32'h1);
		apb(1'b0, OFF_MARKS, 32'h0);
		m = rdv;
		chk(32'(m[9:0]) >> (10 - p), 32'h0);
		apb(1'b1, OFF_RDIDX, {22'h0, m[9:0]});
		rd(OFF_RDTAG, 32'(exp < (1024 >> p)));
		if (exp < (1024 >> p)) rd(OFF_RDLO, tw);
	endtask
	// window mode: the delay only runs once the enable point has passed
	task run_window;
		start(32'h1426, 32'h0, 32'd5, 32'h1);
		pulse(10, 3'b100);
		repeat (20) @(posedge pclk);
		chk(32'(recording), 32'h1);
		enable_evt <= 1;
		@(posedge pclk);
		enable_evt <= 0;
		wait_stop;
		rd(OFF_CYCNUM, 32'd5);
	endtask
	// two partitions in post mode: retrigger in delay, then an extra final trigger
	task run_multi;
		start(32'h404, 32'h1, 32'h0, 32'h2);
		pulse(10, 3'b100);
		pulse(10, 3'b100);
		pulse(10, 3'b100);
		wait_stop;
		rd(OFF_MARKS, 32'h0001_0200);
		rd(OFF_CYCNUM, 32'd511);
	endtask
	// -----------------
	// main sequence
	// -----------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		go <= 1;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_PART, 32'h0);
		rd(OFF_DELAY, 32'h0);
		rd(OFF_COUNT, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(err), 32'h1);
		run_mode(32'h400, 0, 32'h0, 0);
		run_mode(32'h402, 7, 32'h0, 4);
		run_mode(32'h404, 8, 32'h0, 3);
		run_mode(32'h406, 0, 32'd100, 100);
		run_mode(32'h406, 8, 32'd20, 20);
		run_mode(32'h40c, 8, 32'h0, 3);
		qon = 0;
		qa <= 0;
		run_window;
		run_multi;
		start(32'h400, 32'h1, 32'h0, 32'h3);
		pulse(20, 3'b100);
		pulse(20, 3'b100);
		repeat (5) @(posedge pclk);
		chk(32'(recording), 32'h1);
		pulse(20, 3'b100);
		wait_stop;
		apb(1'b0, OFF_MARKS, 32'h0);
		chk(32'(rdv[9]), 32'h0);
		start(32'h500, 32'h0, 32'h0, 32'h2);
		pulse(10, 3'b100);
		pulse(10, 3'b001);
		pulse(10, 3'b100);
		repeat (5) @(posedge pclk);
		chk(32'(recording), 32'h1);
		pulse(10, 3'b100);
		wait_stop;
		chk(32'(emu_halt), 32'h1);
		start(32'h080, 32'h0, 32'h0, 32'h1);
		repeat (30) @(posedge pclk);
		chk(32'(recording), 32'h1);
		pulse(1, 3'b010);
		wait_stop;
		chk(32'(emu_halt), 32'h1);
		give_verdict;
	end
endmodule
`default_nettype wire

// ==== tb/trace_capture_sva.sv ====
// checker of apb timing and capture run/stop behaviour at the ports
// assumes one pclk domain with presetn as its reset
`timescale 1ns/100ps
`default_nettype none
module trace_capture_chk
	import trace_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic manual_brk,
	input wire logic emu_halt,
	input wire logic recording
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb access phase and register write
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_wr;
		psel && pwrite;
	endsequence
	a_ready_one_wait: assert property (s_acc |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_idle_quiet: assert property (!psel |=> !pready) else $error("pready unasked");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
	a_halt_not_rec: assert property (emu_halt |-> !recording) else $error("halted yet recording");
	a_manual_stop: assert property (recording && manual_brk |=> !recording) else $error("manual break ignored");
	a_halt_holds: assert property (emu_halt && !(psel && pwrite) |=> emu_halt) else $error("halt dropped");
	a_rec_by_run: assert property ($rose(recording) |-> $past(psel) && $past(pwrite)) else $error("run unasked");
	a_halt_from_run: assert property ($rose(emu_halt) |-> $past(recording)) else $error("halt while idle");
endmodule
bind trace_capture trace_capture_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .manual_brk(manual_brk),
	.emu_halt(emu_halt), .recording(recording));
`default_nettype wire
